/* logic/ioc_cell.sv */
// Programmable I/O cell: input capture, output and tri-state registers.
//
// Overview of operation
// - The pin level reaches the core unregistered, as a plain signal and as a clock source.
// - In single rate mode one system-clock register captures the pin.
// - In double rate mode a rising-edge and a falling-edge register give two sample streams.
// - The rising sample leaves on the first output, the single rate or falling sample on the second.
// - A fixed delay may precede the capture, and bottom-edge cells also take a 5-bit run-time code.
// - A local set/reset initialises this cell's input, output and tri-state registers alone.
// - The core drives the first output bit always and the second only in double rate mode.
// - The core tri-state control passes through the tri-state register to the buffer.
// - One system clock clocks the input, output and tri-state registers.
//
// Decided for this implementation: the register offsets and the APB interface to the registers.
`timescale 1ns/10ps
module ioc_cell
  import ioc_pkg::*;
#(
  parameter bit         BOTTOM_EDGE = 1'b1,
  parameter int         FIXED_TAP   = 2,
  parameter logic       LSR_VAL     = 1'b0
) (
  input  wire logic                 clk,
  input  wire logic                 rst_n,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [7:0]           paddr,
  input  wire logic [31:0]          pwdata,
  input  wire logic [3:0]           pstrb,
  output logic [31:0]               prdata,
  output logic                      pready,
  output logic                      pslverr,
  input  wire logic                 cell_ce,
  input  wire logic                 local_rst,
  input  wire logic                 pin_in,
  output logic                      bypass_comb_in,
  output logic                      bypass_clock_in,
  output logic                      rise_sample,
  output logic                      fall_or_sdr_sample,
  input  wire logic [IOC_LAG_W-1:0] dynamic_lag_code,
  input  wire logic                 core_out_first,
  input  wire logic                 core_out_second,
  input  wire logic                 core_tristate,
  output logic                      pin_data,
  output logic                      pin_tristate,
  output logic                      stream_ready
);

  // ==========================================================================
  // Control register.
  logic [IOC_CTRL_W-1:0]    ctrl_r;
  logic                     ddr_mode;
  ioc_dly_t                 dly_mode;
  logic                     strm_en;

  assign ddr_mode = ctrl_r[IOC_CTRL_DDR];
  assign dly_mode = ioc_dly_t'(ctrl_r[IOC_CTRL_DLY +: 2]);
  assign strm_en  = ctrl_r[IOC_CTRL_STRM];

  // ==========================================================================
  // APB decode. Zero wait states; unmapped offsets answer with pslverr.
  logic                     acc;
  logic                     wr_acc;
  logic                     rd_acc;
  logic                     hit_ctrl;
  logic                     hit_stat;
  logic                     hit_data;
  logic                     hit_any;

  assign acc      = psel && penable;
  assign hit_ctrl = (paddr == IOC_CTRL_OFS);
  assign hit_stat = (paddr == IOC_STAT_OFS);
  assign hit_data = (paddr == IOC_DATA_OFS);
  assign hit_any  = hit_ctrl || hit_stat || hit_data;
  assign wr_acc   = acc && pwrite && hit_any;
  assign rd_acc   = acc && !pwrite && hit_any;
  assign pready   = 1'b1;
  assign pslverr  = acc && !hit_any;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_r <= IOC_CTRL_RST;
    end else if (wr_acc && hit_ctrl && pstrb[0]) begin
      ctrl_r <= pwdata[IOC_CTRL_W-1:0];
    end
  end

  // ==========================================================================
  // Unregistered input path.
  assign bypass_comb_in  = pin_in;
  assign bypass_clock_in = pin_in;

  // ==========================================================================
  // Pin level seen by software through a three-stage synchroniser.
  logic                     pin_s1_r;
  logic                     pin_s2_r;
  logic                     pin_s3_r;
  logic                     pin_lvl_r;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1_r  <= 1'b0;
      pin_s2_r  <= 1'b0;
      pin_s3_r  <= 1'b0;
      pin_lvl_r <= 1'b0;
    end else begin
      pin_s1_r <= pin_in;
      pin_s2_r <= pin_s1_r;
      pin_s3_r <= pin_s2_r;
      if (pin_s2_r == pin_s3_r) begin
        pin_lvl_r <= pin_s3_r;
      end
    end
  end

  // ==========================================================================
  // Delay line. Each tap is one system clock, so the delay is coarse; tap 0
  // is never selected because it is the metastable first stage.
  logic [IOC_LINE_LEN-1:0]  line_r;
  logic                     cap_d;
  logic [5:0]               dyn_tap;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      line_r <= '0;
    end else begin
      line_r <= {line_r[IOC_LINE_LEN-2:0], pin_in};
    end
  end

  assign dyn_tap = {1'b0, dynamic_lag_code} + 6'h01;

  always_comb begin
    cap_d = pin_in;
    unique case (dly_mode)
      IOC_DLY_FIXED: cap_d = line_r[FIXED_TAP];
      IOC_DLY_DYN: begin
        // Cells away from the bottom edge have no dynamic code; they fall back.
        if (BOTTOM_EDGE) begin
          cap_d = line_r[dyn_tap];
        end else begin
          cap_d = line_r[FIXED_TAP];
        end
      end
      default: cap_d = pin_in;
    endcase
  end

  // ==========================================================================
  // Input capture registers, all on the system clock.
  logic                     rise_r;
  logic                     fall_r;
  logic                     sdr_r;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rise_r <= 1'b0;
      sdr_r  <= 1'b0;
    end else if (local_rst) begin
      rise_r <= LSR_VAL;
      sdr_r  <= LSR_VAL;
    end else if (cell_ce) begin
      if (ddr_mode) begin
        rise_r <= cap_d;
      end else begin
        sdr_r <= cap_d;
      end
    end
  end

  always_ff @(negedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fall_r <= 1'b0;
    end else if (local_rst) begin
      fall_r <= LSR_VAL;
    end else if (cell_ce && ddr_mode) begin
      fall_r <= cap_d;
    end
  end

  assign rise_sample        = rise_r;
  assign fall_or_sdr_sample = ddr_mode ? fall_r : sdr_r;

  // ==========================================================================
  // Output and tri-state registers.
  logic                     out_first_r;
  logic                     out_second_r;
  logic                     tri_r;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      out_first_r  <= 1'b0;
      out_second_r <= 1'b0;
      tri_r        <= 1'b1;
    end else if (local_rst) begin
      out_first_r  <= LSR_VAL;
      out_second_r <= LSR_VAL;
      tri_r        <= LSR_VAL;
    end else if (cell_ce) begin
      out_first_r <= core_out_first;
      tri_r       <= core_tristate;
      if (ddr_mode) begin
        out_second_r <= core_out_second;
      end
    end
  end

  // The phase mux glitches if clk has poor duty cycle; it mirrors a DDR pad.
  assign pin_data     = (ddr_mode && !clk) ? out_second_r : out_first_r;
  assign pin_tristate = tri_r;

  // ==========================================================================
  // Sample stream into the FIFO, drained by reads of the data register.
  logic                     push_v;
  logic                     fifo_in_rdy;
  logic                     fifo_out_v;
  logic [IOC_FIFO_W-1:0]    fifo_out_d;
  logic                     pop;
  logic [IOC_LVL_W-1:0]     level;
  logic                     ovf_r;
  logic                     ovf_clr;

  assign push_v       = strm_en && cell_ce && !local_rst;
  assign pop          = rd_acc && hit_data && fifo_out_v;
  assign stream_ready = fifo_in_rdy;
  assign ovf_clr      = wr_acc && hit_stat && pwdata[IOC_ST_OVF];

  ioc_fifo #(
    .W     (IOC_FIFO_W),
    .DEPTH (IOC_FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .rst_n     (rst_n),
    .in_valid  (push_v),
    .in_ready  (fifo_in_rdy),
    .in_data   ({fall_or_sdr_sample, rise_sample}),
    .out_valid (fifo_out_v),
    .out_ready (pop),
    .out_data  (fifo_out_d),
    .level     (level)
  );

  // A lost sample outranks a clear in the same cycle.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ovf_r <= 1'b0;
    end else if (push_v && !fifo_in_rdy) begin
      ovf_r <= 1'b1;
    end else if (ovf_clr) begin
      ovf_r <= 1'b0;
    end
  end

  // ==========================================================================
  // Read data mux.
  always_comb begin
    prdata = 32'h0000_0000;
    if (rd_acc) begin
      if (hit_ctrl) begin
        prdata[IOC_CTRL_W-1:0] = ctrl_r;
      end
      if (hit_stat) begin
        prdata[IOC_ST_RISE]               = rise_sample;
        prdata[IOC_ST_FALL]               = fall_or_sdr_sample;
        prdata[IOC_ST_TRI]                = tri_r;
        prdata[IOC_ST_PIN]                = pin_lvl_r;
        prdata[IOC_ST_LVL +: IOC_LVL_W]   = level;
        prdata[IOC_ST_OVF]                = ovf_r;
      end
      if (hit_data) begin
        prdata[IOC_DATA_VLD]              = fifo_out_v;
        prdata[IOC_FIFO_W-1:0]            = fifo_out_d;
      end
    end
  end

  // ==========================================================================
  // Assertions.
  property p_bypass;
    @(posedge clk) disable iff (!rst_n)
      bypass_comb_in == pin_in && bypass_clock_in == pin_in;
  endproperty
  a_bypass: assert property (p_bypass) else $error("bypass differs from pin");

  property p_sdr_cap;
    @(posedge clk) disable iff (!rst_n)
      !ddr_mode && cell_ce && !local_rst ##1 !ddr_mode
        |-> fall_or_sdr_sample == $past(cap_d);
  endproperty
  a_sdr_cap: assert property (p_sdr_cap) else $error("sdr capture wrong");

  property p_ddr_rise;
    @(posedge clk) disable iff (!rst_n)
      ddr_mode && cell_ce && !local_rst |=> rise_sample == $past(cap_d);
  endproperty
  a_ddr_rise: assert property (p_ddr_rise) else $error("rise capture wrong");

  property p_ddr_fall;
    @(negedge clk) disable iff (!rst_n)
      ddr_mode && cell_ce && !local_rst |=> fall_r == $past(cap_d);
  endproperty
  a_ddr_fall: assert property (p_ddr_fall) else $error("fall capture wrong");

  property p_second_out;
    @(posedge clk) disable iff (!rst_n)
      fall_or_sdr_sample == (ddr_mode ? fall_r : sdr_r);
  endproperty
  a_second_out: assert property (p_second_out) else $error("second output mux");

  property p_fixed_dly;
    @(posedge clk) disable iff (!rst_n)
      dly_mode == IOC_DLY_FIXED ##2 dly_mode == IOC_DLY_FIXED
        |-> cap_d == $past(pin_in, FIXED_TAP + 1);
  endproperty
  a_fixed_dly: assert property (p_fixed_dly) else $error("fixed delay wrong");

  property p_lsr;
    @(posedge clk) disable iff (!rst_n)
      local_rst |=> out_first_r == LSR_VAL && tri_r == LSR_VAL && rise_r == LSR_VAL;
  endproperty
  a_lsr: assert property (p_lsr) else $error("local reset missed");

  property p_out_first;
    @(posedge clk) disable iff (!rst_n)
      cell_ce && !local_rst |=> out_first_r == $past(core_out_first);
  endproperty
  a_out_first: assert property (p_out_first) else $error("output data lost");

  property p_tri;
    @(posedge clk) disable iff (!rst_n)
      cell_ce && !local_rst |=> pin_tristate == $past(core_tristate);
  endproperty
  a_tri: assert property (p_tri) else $error("tri-state not forwarded");

  property p_hold;
    @(posedge clk) disable iff (!rst_n)
      !cell_ce && !local_rst |=> $stable(out_first_r) && $stable(rise_r) && $stable(sdr_r);
  endproperty
  a_hold: assert property (p_hold) else $error("register moved without enable");

  property p_phase_lo;
    @(posedge clk) disable iff (!rst_n)
      ddr_mode |-> pin_data == out_second_r;
  endproperty
  a_phase_lo: assert property (p_phase_lo) else $error("low phase bit wrong");

  property p_phase_hi;
    @(negedge clk) disable iff (!rst_n)
      ddr_mode |-> pin_data == out_first_r;
  endproperty
  a_phase_hi: assert property (p_phase_hi) else $error("high phase bit wrong");

  property p_ovf;
    @(posedge clk) disable iff (!rst_n)
      push_v && !fifo_in_rdy |=> ovf_r;
  endproperty
  a_ovf: assert property (p_ovf) else $error("overflow not flagged");

  c_ddr: cover property (@(posedge clk) ddr_mode && cell_ce ##1 ddr_mode && cell_ce);
  c_full: cover property (@(posedge clk) strm_en && !fifo_in_rdy);
  c_pop: cover property (@(posedge clk) pop);
  c_dyn: cover property (@(posedge clk) dly_mode == IOC_DLY_DYN && cell_ce);

endmodule : ioc_cell

/* logic/ioc_fifo.sv */
// Sample FIFO with a registered output stage.
`timescale 1ns/10ps
module ioc_fifo #(
  parameter int W     = 2,
  parameter int DEPTH = 16
) (
  input  wire logic                       clk,
  input  wire logic                       rst_n,
  input  wire logic                       in_valid,
  output logic                            in_ready,
  input  wire logic [W-1:0]               in_data,
  output logic                            out_valid,
  input  wire logic                       out_ready,
  output logic [W-1:0]                    out_data,
  output logic [$clog2(DEPTH+1):0]        level
);
  localparam int AW = $clog2(DEPTH);

  logic [W-1:0]             mem_r [DEPTH];
  logic [AW-1:0]            wptr_r;
  logic [AW-1:0]            rptr_r;
  logic [$clog2(DEPTH+1):0] cnt_r;
  logic                     push;
  logic                     load;

  // ==========================================================================
  // Handshakes. The output register adds one word of slack beyond DEPTH.
  assign in_ready = (cnt_r != DEPTH[$clog2(DEPTH+1):0]);
  assign push     = in_valid && in_ready;
  assign load     = (cnt_r != '0) && (!out_valid || out_ready);
  assign level    = cnt_r + {{$clog2(DEPTH+1){1'b0}}, out_valid};

  always_ff @(posedge clk) begin
    if (push) begin
      mem_r[wptr_r] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wptr_r <= '0;
      rptr_r <= '0;
      cnt_r  <= '0;
    end else begin
      if (push) begin
        wptr_r <= wptr_r + 1'b1;
      end
      if (load) begin
        rptr_r <= rptr_r + 1'b1;
      end
      cnt_r <= cnt_r + {{$clog2(DEPTH+1){1'b0}}, push}
                     - {{$clog2(DEPTH+1){1'b0}}, load};
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      out_valid <= 1'b0;
      out_data  <= '0;
    end else if (load) begin
      out_valid <= 1'b1;
      out_data  <= mem_r[rptr_r];
    end else if (out_ready) begin
      out_valid <= 1'b0;
    end
  end

  property p_fifo_bound;
    @(posedge clk) disable iff (!rst_n)
      cnt_r <= DEPTH;
  endproperty
  a_fifo_bound: assert property (p_fifo_bound) else $error("fifo count overran depth");

endmodule : ioc_fifo

/* logic/ioc_pkg.sv */
// Shared constants for the I/O cell capture block.
package ioc_pkg;

  // ==========================================================================
  // Register map (byte offsets on the APB side).
  localparam logic [7:0]  IOC_CTRL_OFS   = 8'h00;
  localparam logic [7:0]  IOC_STAT_OFS   = 8'h04;
  localparam logic [7:0]  IOC_DATA_OFS   = 8'h08;

  // ==========================================================================
  // Control register fields and reset value.
  localparam int          IOC_CTRL_DDR   = 0;
  localparam int          IOC_CTRL_DLY   = 1;
  localparam int          IOC_CTRL_STRM  = 3;
  localparam int          IOC_CTRL_W     = 4;
  localparam logic [3:0]  IOC_CTRL_RST   = 4'h0;

  // ==========================================================================
  // Status and data register fields.
  localparam int          IOC_ST_RISE    = 0;
  localparam int          IOC_ST_FALL    = 1;
  localparam int          IOC_ST_TRI     = 2;
  localparam int          IOC_ST_PIN     = 3;
  localparam int          IOC_ST_LVL     = 4;
  localparam int          IOC_ST_OVF     = 16;
  localparam int          IOC_DATA_VLD   = 31;

  // ==========================================================================
  // Delay line and stream sizing.
  localparam int          IOC_LAG_W      = 5;
  localparam int          IOC_LINE_LEN   = 33;
  localparam int          IOC_FIFO_DEPTH = 16;
  localparam int          IOC_FIFO_W     = 2;
  localparam int          IOC_LVL_W      = 6;

  typedef enum logic [1:0] {
    IOC_DLY_NONE  = 2'b00,
    IOC_DLY_FIXED = 2'b01,
    IOC_DLY_DYN   = 2'b10
  } ioc_dly_t;

endpackage : ioc_pkg

/* sim/ioc_pin_model.sv */
// Pin buffer model: far driver, cell drive and loopback into the input receiver.
`timescale 1ns/10ps
module ioc_pin_model (
  input  wire logic clk,
  input  wire logic ext_hi,
  input  wire logic ext_lo,
  input  wire logic pin_data,
  input  wire logic pin_tristate,
  output wire logic pin_in
);
  logic ext_r;

  // The far driver moves a quarter cycle after each edge, clear of both capture edges.
  initial ext_r = 1'b1;
  always @(posedge clk) ext_r <= #6 ext_hi;
  always @(negedge clk) ext_r <= #6 ext_lo;

  // The cell owns the pad while its enable is low; the receiver sees the pad slightly late.
  assign #2 pin_in = pin_tristate ? ext_r : pin_data;

endmodule : ioc_pin_model

/* sim/test_io_cell_capture_register.sv */
// Self-checking bench for the I/O cell: capture, output, tri-state and sample stream.
`timescale 1ns/10ps
module test_io_cell_capture_register
  import ioc_pkg::*;
;
  localparam int N       = 60;
  localparam int TAP_FIX = 2;
  typedef struct packed {logic chk; logic [4:0] eh; logic [2:0] el;} ioc_note_t;

  logic                 clk, rst_n, psel, penable, pwrite, pready, pslverr;
  logic [7:0]           paddr;
  logic [31:0]          pwdata, prdata, rd;
  logic [3:0]           pstrb;
  logic                 cell_ce, local_rst, pin_in, bypass_comb_in, bypass_clock_in;
  logic                 rise_sample, fall_or_sdr_sample, pin_data, pin_tristate;
  logic [IOC_LAG_W-1:0] dynamic_lag_code;
  logic                 core_out_first, core_out_second, core_tristate, stream_ready;
  logic                 ext_hi, ext_lo, watch, er;
  logic                 m_rise, m_sdr, m_fall, m_of, m_os, m_tri;
  logic [6:0]           stim [0:N];
  logic                 pl [0:N];
  int                   errors, tests_run, n;
  integer               seed;
  ioc_note_t            notes[$];
  ioc_note_t            nt;

  ioc_cell #(.BOTTOM_EDGE(1'b1), .FIXED_TAP(TAP_FIX), .LSR_VAL(1'b0)) dut (
    .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cell_ce(cell_ce), .local_rst(local_rst), .pin_in(pin_in),
    .bypass_comb_in(bypass_comb_in), .bypass_clock_in(bypass_clock_in),
    .rise_sample(rise_sample), .fall_or_sdr_sample(fall_or_sdr_sample),
    .dynamic_lag_code(dynamic_lag_code), .core_out_first(core_out_first),
    .core_out_second(core_out_second), .core_tristate(core_tristate),
    .pin_data(pin_data), .pin_tristate(pin_tristate), .stream_ready(stream_ready));
  ioc_pin_model partner (.clk(clk), .ext_hi(ext_hi), .ext_lo(ext_lo), .pin_data(pin_data),
                         .pin_tristate(pin_tristate), .pin_in(pin_in));

  always #12.5 clk = ~clk;

  // ==========================================================================
  // Shared tasks.
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : conclude

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int k;
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    pstrb   <= 4'hf;
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k >= 20) begin
      errors++;
      conclude();
    end
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic drive(input logic [6:0] v);
    {cell_ce, local_rst, core_out_first, core_out_second, core_tristate, ext_hi, ext_lo} <= v;
  endtask : drive

  // ==========================================================================
  // One capture run; the model steps once per rising edge, one note per cycle.
  task automatic run(input logic ddr, input logic [1:0] dm, input logic [4:0] code);
    int   d, skip;
    logic ph, fo, ce, lr;
    @(posedge clk);
    dynamic_lag_code <= code;
    apb(1'b1, IOC_CTRL_OFS, {28'h000_0000, 1'b0, dm, ddr});
    d = (dm == IOC_DLY_FIXED) ? TAP_FIX + 1 : (dm == IOC_DLY_DYN) ? int'(code) + 2 : 0;
    skip = (d == 0) ? 0 : d + 2;
    for (int i = 0; i <= N; i++) begin
      ce = (i == 0 || i == N) ? 1'b0 : (i <= skip) ? 1'b1 : 1'($random(seed));
      lr = (i > skip && i < N) ? ($random(seed) % 9 == 0) : 1'b0;
      stim[i] = {ce, lr, 5'($random(seed))};
    end
    pl[0] = m_tri ? stim[0][0] : (ddr ? m_os : m_of);
    for (int k = 0; k < N; k++) begin
      @(posedge clk);
      drive(stim[k]);
      watch <= 1'b1;
      fo = m_fall;
      if (stim[k][5]) begin
        {m_rise, m_sdr, m_of, m_os, m_tri} = 5'h00;
      end else if (stim[k][6]) begin
        m_of  = stim[k][4];
        m_tri = stim[k][2];
        if (ddr) begin
          m_rise = pl[k];
          m_os   = stim[k][3];
        end else begin
          m_sdr = pl[(k >= d) ? k - d : 0];
        end
      end
      // The far driver takes its high-phase level at the edge, before this cycle's drive lands.
      ph = m_tri ? stim[k][1] : m_of;
      pl[k+1] = m_tri ? stim[k+1][0] : (ddr ? m_os : m_of);
      if (stim[k+1][5]) begin
        m_fall = 1'b0;
      end else if (stim[k+1][6] && ddr) begin
        m_fall = ph;
      end
      notes.push_back({k >= skip, m_rise, ddr ? fo : m_sdr, m_of, m_tri, ph,
                       ddr ? m_fall : m_sdr, ddr ? m_os : m_of, pl[k+1]});
    end
    @(posedge clk);
    drive(stim[N]);
    watch <= 1'b0;
    $display("Capture run finished: ddr %0d delay mode %0d code %0d", ddr, dm, code);
  endtask : run

  // ==========================================================================
  // Output watcher: high-phase view, then low-phase view of each cycle.
  always @(posedge clk) begin
    if (watch === 1'b1) begin
      #10;
      nt = notes.pop_front();
      if (nt.chk) begin
        check(rise_sample, nt.eh[4]);
        check(fall_or_sdr_sample, nt.eh[3]);
        check(pin_data, nt.eh[2]);
        check(pin_tristate, nt.eh[1]);
        check(bypass_comb_in, nt.eh[0]);
        check(bypass_clock_in, nt.eh[0]);
      end
      #12.5;
      if (nt.chk) begin
        check(fall_or_sdr_sample, nt.el[2]);
        check(pin_data, nt.el[1]);
        check(bypass_comb_in, nt.el[0]);
      end
    end
  end

  // ==========================================================================
  // Main sequence.
  initial begin
    {clk, rst_n, psel, penable, pwrite, watch} = 6'h00;
    {paddr, pwdata, pstrb, dynamic_lag_code} = '0;
    {cell_ce, local_rst, core_out_first, core_out_second, core_tristate} = 5'h00;
    {ext_hi, ext_lo} = 2'b11;
    {m_rise, m_sdr, m_fall, m_of, m_os, m_tri} = 6'h01;
    errors = 0;
    tests_run = 0;
    seed = 32'he2a5_4dc0;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    #1;
    check(pin_tristate, 1'b1);
    check({pin_data, rise_sample, fall_or_sdr_sample}, 3'b000);
    apb(1'b0, IOC_CTRL_OFS, 32'h0000_0000);
    check(rd, {28'h000_0000, IOC_CTRL_RST});
    apb(1'b0, 8'h0c, 32'h0000_0000);
    check(er, 1'b1);
    check(rd, 32'h0000_0000);
    $display("Reset and register access finished");
    run(1'b0, IOC_DLY_NONE, 5'h00);
    run(1'b1, IOC_DLY_NONE, 5'h00);
    run(1'b0, IOC_DLY_FIXED, 5'h00);
    run(1'b0, IOC_DLY_DYN, 5'h05);
    run(1'b0, IOC_DLY_DYN, 5'h1f);
    run(1'b1, 2'b11, 5'h00);
    // Stream: fill until refused, clear the sticky overflow, then drain through DATA.
    @(posedge clk);
    drive(7'b1000111);
    // Let both capture registers settle on the idle-high pad before streaming.
    apb(1'b1, IOC_CTRL_OFS, 32'h0000_0000);
    apb(1'b1, IOC_CTRL_OFS, 32'h0000_0008);
    n = 0;
    while (stream_ready !== 1'b0 && n < 60) begin
      @(posedge clk);
      n++;
    end
    check(stream_ready, 1'b0);
    apb(1'b0, IOC_STAT_OFS, 32'h0000_0000);
    check({rd[IOC_ST_OVF], rd[IOC_ST_LVL+:IOC_LVL_W]}, {1'b1, 6'(IOC_FIFO_DEPTH + 1)});
    apb(1'b1, IOC_CTRL_OFS, 32'h0000_0000);
    apb(1'b1, IOC_STAT_OFS, 32'h0001_0000);
    apb(1'b0, IOC_STAT_OFS, 32'h0000_0000);
    check(rd[IOC_ST_OVF], 1'b0);
    for (int i = 0; i <= IOC_FIFO_DEPTH + 1; i++) begin
      apb(1'b0, IOC_DATA_OFS, 32'h0000_0000);
      check({rd[IOC_DATA_VLD], rd[1:0]}, (i > IOC_FIFO_DEPTH) ? 3'b011 : 3'b111);
    end
    check(stream_ready, 1'b1);
    $display("Sample stream fill and drain finished");
    conclude();
  end

endmodule : test_io_cell_capture_register
